// *** core/gcr_bank.sv ***
// global configuration register bank with spi access and diag routing
`timescale 1ns/1ps
`default_nettype none
module gcr_bank (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // spi pins
    input  wire logic                        spiClk,
    input  wire logic                        spiCsN,
    input  wire logic                        spiDataIn,
    output var  logic                        spiDataOut,
    // driver side status inputs
    input  wire logic                        driver_disable_n,
    input  wire logic                        offTimeZero,
    input  wire logic                        stepIn,
    input  wire logic                        dirIn,
    input  wire logic                        over_temp_flag,
    input  wire logic                        short_to_ground_flag,
    input  wire logic                        pump_undervolt_flag,
    input  wire logic                        hotWarning,
    input  wire logic                        stallFlag,
    input  wire logic                        indexPos,
    input  wire logic                        chopperOnSecond,
    input  wire logic                        lostStepInc,
    // controls toward the driver core
    output var  logic                        recalibrate,
    output var  logic                        quietChopEnable,
    output var  logic                        stepFilterEnable,
    output var  logic                        motorDir,
    output var  logic                        standstill,
    // diagnostic pins, open collector when enable alone is used
    output var  logic                        diagOutA,
    output var  logic                        diagOutAEn,
    output var  logic                        diagOutB,
    output var  logic                        diagOutBEn,
    // raw register view
    output var  logic [gcr_pkg::CfgWidth-1:0] global_configuration_flags
);
    import gcr_pkg::*;

    logic [CfgWidth-1:0]  cfg_reg;
    logic [CfgWidth-1:0]  cfg_next;
    logic [2:0]           status_reg;
    logic [2:0]           status_next;
    logic                 toggleB_reg;
    logic                 stepPrev_reg;
    logic [FrameBits-1:0] reply_reg;
    logic [FrameBits-1:0] frameWord;
    logic                 frameDone;

    // field decode of the command word
    wire [7:0]          cmdByte  = frameWord[FrameBits-1:DataBits];
    wire [AddrBits-1:0] cmdAddr  = cmdByte[AddrBits-1:0];
    wire                cmdWrite = cmdByte[WriteBitPos]; // see R2
    wire [DataBits-1:0] cmdData  = frameWord[DataBits-1:0];

    function automatic logic hit(input logic [AddrBits-1:0] a,
                                 input logic [AddrBits-1:0] b);
        hit = (a == b);
    endfunction : hit

    wire wrCfg    = frameDone & cmdWrite & hit(cmdAddr, AddrConfig);
    wire wrStatus = frameDone & cmdWrite & hit(cmdAddr, AddrStatus);
    wire driverFault = over_temp_flag | short_to_ground_flag;

    // upper data bits never reach storage
    assign cfg_next = wrCfg ? cmdData[CfgWidth-1:0] : cfg_reg; // see R22

    // status flags: set wins over a simultaneous write-one clear
    wire [2:0] clrMask = wrStatus ? cmdData[2:0] : 3'h0; // see R3
    wire [2:0] setMask = {pump_undervolt_flag, driverFault, 1'b0};
    assign status_next = (status_reg & ~clrMask) | setMask; // see R3

    // read data selection; unmapped addresses read zero
    wire [DataBits-1:0] rdCfg = {{(DataBits-CfgWidth){1'b0}}, cfg_reg};
    wire [DataBits-1:0] rdSt  = {{(DataBits-3){1'b0}}, status_reg};
    wire [DataBits-1:0] rdData =
        hit(cmdAddr, AddrConfig) ? rdCfg :
        hit(cmdAddr, AddrStatus) ? rdSt  : '0; // see R4

    // status byte latched at end of access, sent with the next reply
    wire [7:0] statusByte = {4'h0, standstill, stallFlag,
                             status_reg[StDrvErr], status_reg[StResetFlag]};

    // config and reply registers update at chip select rise only; status flags set on any clock
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg       <= CfgReset; // see R1
            status_reg    <= StatusReset;
            reply_reg     <= '0;
        end else begin
            cfg_reg    <= cfg_next;
            status_reg <= status_next;
            if (frameDone) begin
                reply_reg     <= {statusByte, rdData}; // see R21
            end
        end
    end

    // lost step toggle for output B, cleared while the option is off
    always_ff @(posedge clock) begin
        if (rst) begin
            toggleB_reg  <= 1'b0;
            stepPrev_reg <= 1'b0;
        end else begin
            stepPrev_reg <= stepIn;
            if (!cfg_reg[BitBLostStep]) begin
                toggleB_reg <= 1'b0;
            end else if (lostStepInc) begin
                toggleB_reg <= ~toggleB_reg; // see R17
            end
        end
    end

    wire stepEvent = stepIn & ~stepPrev_reg;

    gcr_spi_shift uShift (
        .clock      (clock),
        .rst        (rst),
        .spiClk     (spiClk),
        .spiCsN     (spiCsN),
        .spiDataIn  (spiDataIn),
        .spiDataOut (spiDataOut),
        .replyWord  (reply_reg),
        .frameWord  (frameWord),
        .frameDone  (frameDone)
    );

    gcr_standstill uStill (
        .clock      (clock),
        .rst        (rst),
        .stepEvent  (stepEvent),
        .fastMode   (cfg_reg[BitFastStill]),
        .standstill (standstill)
    );

    // driver controls
    assign recalibrate = cfg_reg[BitRecal] &
                         (~driver_disable_n | offTimeZero); // see R5
    assign quietChopEnable  = cfg_reg[BitQuietChop]; // see R7
    assign stepFilterEnable = cfg_reg[BitStepFilt]; // see R8
    assign motorDir = dirIn ^ cfg_reg[BitInvDir]; // see R9
    assign global_configuration_flags = cfg_reg;

    // diagnostic event routing, active sense before drive selection
    wire eventA = (cfg_reg[BitAFault] &
                   (driverFault | pump_undervolt_flag)) | // see R10
                  (cfg_reg[BitAHot] & hotWarning) | // see R12
                  (cfg_reg[BitAStall] & stallFlag); // see R13
    wire eventB = (cfg_reg[BitBStall] & stallFlag) | // see R14
                  (cfg_reg[BitBIndex] & indexPos) | // see R15
                  (cfg_reg[BitBChopOn] & chopperOnSecond) | // see R16
                  toggleB_reg; // see R17

    // reset forces A active; pushA is masked by rst, so open collector low
    wire activeA = eventA | rst; // see R11
    wire pushA   = cfg_reg[BitADrive] & ~rst;

    // push pull drives the level high-active; open collector pulls low only
    assign diagOutA   = pushA ? activeA : 1'b0; // see R18
    assign diagOutAEn = pushA ? 1'b1 : activeA; // see R18
    assign diagOutB   = cfg_reg[BitBDrive] ? eventB : 1'b0; // see R19
    assign diagOutBEn = cfg_reg[BitBDrive] ? 1'b1 : eventB; // see R19
endmodule : gcr_bank
`default_nettype wire

// *** core/gcr_pkg.sv ***
// constants and field layout for the global configuration register bank
//
// Contract
// R1 - power up clears registers to zero; the status register loads 1 (reset flag set)
// R2 - write address carries plus 0x80 offset
// R3 - writing one clears flag, zero keeps it
// R4 - registers honour read, write, clear classes
// R5 - bit 0 recalibrates while driver disabled
// R6 - bit 1 selects 2^18 or 2^20 timeout
// R7 - bit 2 enables quiet voltage chopper
// R8 - bit 3 filters external step input
// R9 - bit 4 reverses motor direction
// R10 - bit 5 routes driver error onto A
// R11 - output A active low during reset
// R12 - bit 6 routes hot warning onto A
// R13 - bit 7 routes stall onto A
// R14 - bit 8 routes stall onto B
// R15 - bit 9 routes index position onto B
// R16 - bit 10 routes chopper on phase onto B
// R17 - bit 11 toggles B on lost step
// R18 - bit 12 selects drive of A
// R19 - bit 13 selects drive of B
// R20 - command executes on chip select rise
// R21 - reply top byte holds status bits
// R22 - unimplemented config bits read zero
package gcr_pkg;
    localparam int           FrameBits      = 40;
    localparam int           AddrBits       = 7;
    localparam int           DataBits       = 32;
    localparam int           CfgWidth       = 18;
    localparam logic [7:0]   WriteFlag      = 8'h80;
    localparam int           WriteBitPos    = 7;
    localparam logic [6:0]   AddrConfig     = 7'h00;
    localparam logic [6:0]   AddrStatus     = 7'h01;
    localparam logic [17:0]  CfgReset       = 18'h00000;
    localparam logic [2:0]   StatusReset    = 3'h1;
    localparam int           BitRecal       = 0;
    localparam int           BitFastStill   = 1;
    localparam int           BitQuietChop   = 2;
    localparam int           BitStepFilt    = 3;
    localparam int           BitInvDir      = 4;
    localparam int           BitAFault      = 5;
    localparam int           BitAHot        = 6;
    localparam int           BitAStall      = 7;
    localparam int           BitBStall      = 8;
    localparam int           BitBIndex      = 9;
    localparam int           BitBChopOn     = 10;
    localparam int           BitBLostStep   = 11;
    localparam int           BitADrive      = 12;
    localparam int           BitBDrive      = 13;
    localparam int           StResetFlag    = 0;
    localparam int           StDrvErr       = 1;
    localparam int           StPumpUv       = 2;
    localparam int           StillShortLog2 = 18;
    localparam int           StillLongLog2  = 20;
    localparam int           StillCntW      = 21;
    localparam logic [20:0]  StillShort     = 21'h040000;
    localparam logic [20:0]  StillLong      = 21'h100000;
endpackage : gcr_pkg

// *** core/gcr_spi_shift.sv ***
// spi mode 3 shifter: samples data, drives reply, flags chip select rise
`timescale 1ns/1ps
`default_nettype none
module gcr_spi_shift (
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst,
    // spi pins, synchronous to clock
    input  wire logic                           spiClk,
    input  wire logic                           spiCsN,
    input  wire logic                           spiDataIn,
    output var  logic                           spiDataOut,
    // frame side
    input  wire logic [gcr_pkg::FrameBits-1:0]  replyWord,
    output var  logic [gcr_pkg::FrameBits-1:0]  frameWord,
    output logic                                frameDone
);
    import gcr_pkg::*;

    logic                 sckPrev_reg;
    logic                 csPrev_reg;
    logic [FrameBits-1:0] shift_reg;
    wire                  sckRise = spiClk & ~sckPrev_reg;
    wire                  sckFall = ~spiClk & sckPrev_reg;
    logic                 done_reg;
    wire                  csFall  = ~spiCsN & csPrev_reg;
    wire                  csRise  = spiCsN & ~csPrev_reg;

    // the last 40 bits shifted in form the command; extra bits chain out
    // done is registered on the same edge as the latch so the decode sees the new word
    assign frameDone = done_reg; // see R20

    // edge tracking and shifting; reply loaded when chip select falls
    always_ff @(posedge clock) begin
        if (rst) begin
            sckPrev_reg <= 1'b1;
            csPrev_reg  <= 1'b1;
            shift_reg   <= '0;
            spiDataOut  <= 1'b0;
            frameWord   <= '0;
            done_reg    <= 1'b0;
        end else begin
            sckPrev_reg <= spiClk;
            csPrev_reg  <= spiCsN;
            done_reg    <= csRise; // see R20
            if (csFall) begin
                shift_reg  <= replyWord;
                spiDataOut <= replyWord[FrameBits-1];
            end else if (!spiCsN && sckRise) begin
                shift_reg <= {shift_reg[FrameBits-2:0], spiDataIn};
            end else if (!spiCsN && sckFall) begin
                spiDataOut <= shift_reg[FrameBits-1];
            end
            if (csRise) begin
                frameWord <= shift_reg; // see R20
            end
        end
    end
endmodule : gcr_spi_shift
`default_nettype wire

// *** core/gcr_standstill.sv ***
// standstill timer counting clocks since the last step
`timescale 1ns/1ps
`default_nettype none
module gcr_standstill (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // control
    input  wire logic stepEvent,
    input  wire logic fastMode,
    // result
    output var  logic standstill
);
    import gcr_pkg::*;

    logic [StillCntW-1:0] count_reg;
    // the limit follows the mode bit live, so a switch applies at once
    wire  [StillCntW-1:0] limit = fastMode ? StillShort : StillLong; // see R6
    wire                  atLimit = (count_reg >= limit);

    // counter saturates at the limit rather than wrapping
    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg  <= '0;
            standstill <= 1'b0;
        end else begin
            if (stepEvent) begin
                count_reg <= '0;
            end else if (!atLimit) begin
                count_reg <= count_reg + 1'b1;
            end
            standstill <= atLimit & ~stepEvent; // see R6
        end
    end
endmodule : gcr_standstill
`default_nettype wire

// *** tb/gcr_bank_sva.sv ***
// assertions on the register bank pins
`timescale 1ns/1ps
`default_nettype none
module gcr_bank_sva
    import gcr_pkg::*;
(
    // clock and reset
    input wire logic                         clock,
    input wire logic                         rst,
    // watched pins
    input wire logic                         spiCsN,
    input wire logic                         driver_disable_n,
    input wire logic                         offTimeZero,
    input wire logic                         dirIn,
    input wire logic                         hotWarning,
    input wire logic                         indexPos,
    input wire logic                         stepIn,
    input wire logic                         standstill,
    input wire logic                         recalibrate,
    input wire logic                         quietChopEnable,
    input wire logic                         motorDir,
    input wire logic                         diagOutA,
    input wire logic                         diagOutAEn,
    input wire logic                         diagOutB,
    input wire logic [gcr_pkg::CfgWidth-1:0] global_configuration_flags
);
    wire [CfgWidth-1:0] cfg = global_configuration_flags;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // reset must show on pin A even though every other check is off then
    a_reset_drives_a: assert property (disable iff (1'b0)
        rst ##1 rst |-> !diagOutA && diagOutAEn)
        else $error("pin A not driven low in reset");
    a_recal_cond: assert property (recalibrate ==
        (cfg[BitRecal] && (!driver_disable_n || offTimeZero)))
        else $error("recalibrate wrong");
    a_dir_invert: assert property (motorDir == (dirIn ^ cfg[BitInvDir]))
        else $error("motor direction wrong");
    a_quiet_mode: assert property (quietChopEnable == cfg[BitQuietChop])
        else $error("quiet chopper enable wrong");
    // past value guards the cycle in which the drive bit changes
    a_a_push_pull: assert property (cfg[BitADrive] &&
        $past(cfg[BitADrive]) |-> diagOutAEn)
        else $error("pin A push pull not driven");
    a_b_open_drain: assert property (!cfg[BitBDrive] &&
        !$past(cfg[BitBDrive]) |-> !diagOutB)
        else $error("pin B open collector drives high");
    a_hot_to_a: assert property ((cfg[BitAHot] && cfg[BitADrive] &&
        hotWarning)[*2] |-> ##[0:2] diagOutA)
        else $error("hot warning missing on pin A");
    a_index_to_b: assert property ((cfg[BitBIndex] && cfg[BitBDrive] &&
        indexPos)[*2] |-> ##[0:2] diagOutB)
        else $error("index missing on pin B");
    a_cfg_on_frame: assert property ($changed(cfg) |-> spiCsN)
        else $error("config changed inside a frame");
    a_step_clears_still: assert property (
        $rose(stepIn) |=> !standstill)
        else $error("standstill not cleared by step");
    // main scenarios reached
    c_b_active: cover property (diagOutB && cfg[BitBDrive]);
    c_recal: cover property (recalibrate);
    c_frame_end: cover property ($rose(spiCsN));
endmodule : gcr_bank_sva
`default_nettype wire

// *** tb/gcr_host_model.sv ***
// spi mode 3 host model shifting one 40-bit frame
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model (
    // pacing clock
    input  wire logic clock,
    // spi pins
    output var  logic spiClk,
    output var  logic spiCsN,
    output var  logic spiDataIn,
    input  wire logic spiDataOut
);
    // idle: clock high, not selected
    initial begin
        spiClk = 1'b1;
        spiCsN = 1'b1;
        spiDataIn = 1'b0;
    end
    // three clocks a half period, above the two-clock minimum
    task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
        @(posedge clock);
        #5 spiCsN = 1'b0;
        for (int i = 39; i >= 0; i--) begin
            repeat (3) @(posedge clock);
            #5 spiClk = 1'b0;
            spiDataIn = tx[i];
            repeat (3) @(posedge clock);
            #5 rx[i] = spiDataOut;
            spiClk = 1'b1;
        end
        repeat (3) @(posedge clock);
        #5 spiCsN = 1'b1;
        spiDataIn = ~spiDataIn; // released line keeps no stale value
        repeat (3) @(posedge clock);
        #5;
    endtask : xfer
endmodule : gcr_host_model
`default_nettype wire

// *** tb/tb_gcr_bank.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_gcr_bank;
    import gcr_pkg::*;
    logic clock = 0, rst = 1, disN = 1, offZ = 0, dir = 0, lost = 0;
    logic [6:0] src = '0;
    logic sck, csN, mosi, miso, recal, quiet, filt, mDir, dA, dAEn, dB, dBEn;
    logic pp, v, still, stp = 0;
    logic [17:0] cfg;
    logic [39:0] rx;
    logic [7:0] e;
    logic [1:0] act, idl;
    logic [3:0] x;
    logic [7:0] tbl [8] = '{8'h28, 8'h29, 8'h2a, 8'h33, 8'h3c, 8'hc4, 8'hcd,
        8'hd6}; // {pin B, config bit, source}
    wire [3:0] pins = {dA, dAEn, dB, dBEn};
    int fails = 0, compares = 0, cyc = 0;
    gcr_bank gcr_bank_inst (.clock(clock), .rst(rst), .spiClk(sck),
        .spiCsN(csN), .spiDataIn(mosi), .spiDataOut(miso),
        .driver_disable_n(disN), .offTimeZero(offZ), .stepIn(stp),
        .dirIn(dir), .over_temp_flag(src[0]), .short_to_ground_flag(src[1]),
        .pump_undervolt_flag(src[2]), .hotWarning(src[3]),
        .stallFlag(src[4]), .indexPos(src[5]), .chopperOnSecond(src[6]),
        .lostStepInc(lost), .recalibrate(recal), .quietChopEnable(quiet),
        .stepFilterEnable(filt), .motorDir(mDir), .standstill(still),
        .diagOutA(dA), .diagOutAEn(dAEn), .diagOutB(dB), .diagOutBEn(dBEn),
        .global_configuration_flags(cfg));
    gcr_host_model host_inst (.clock(clock), .spiClk(sck), .spiCsN(csN),
        .spiDataIn(mosi), .spiDataOut(miso));
    initial forever #25 clock = ~clock;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask : tick
    task automatic xfer(input logic [7:0] a, input logic [31:0] d);
        host_inst.xfer({a, d}, rx);
    endtask : xfer
    // a read answers in the following frame
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 32'h0);
        xfer(a, 32'h0);
        `CHK("rdData", d, rx[31:0])
    endtask : rd
    task tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        tick(20);
        `CHK("resetA", 2'b01, {dA, dAEn})
        rst = 0;
        tick(2);
        `CHK("cfgPowerUp", 18'h0, cfg)
        rd(8'h00, 32'h0);
        `CHK("status", 8'h01, rx[39:32])
        xfer(8'h81, 32'h0);
        rd(8'h01, 32'h1);
        xfer(8'h81, 32'h1);
        rd(8'h01, 32'h0);
        xfer(8'h80, 32'hffffffff);
        `CHK("cfgAll", 18'h3ffff, cfg)
        rd(8'h00, 32'h3ffff);
        `CHK("cfgKept", 18'h3ffff, cfg)
        rd(8'h05, 32'h0);
        disN = 0;
        dir = 1;
        tick(2);
        `CHK("ctrl", 4'b1110, {recal, quiet, filt, mDir})
        disN = 1;
        tick(2);
        `CHK("recalOff", 1'b0, recal)
        offZ = 1;
        tick(2);
        `CHK("recalOffTime", 1'b1, recal)
        offZ = 0;
        // every routing but the lost step toggle, in both drive types
        for (int k = 0; k < 16; k++) begin
            e = tbl[k % 8];
            pp = (k >= 8);
            act = pp ? 2'b11 : 2'b01;
            idl = pp ? 2'b01 : 2'b00;
            src = '0;
            xfer(8'h81, 32'h6);
            xfer(8'h80, (32'h1 << e[6:3]) | (pp ? 32'h3000 : 32'h0));
            `CHK("idle", {idl, idl}, pins)
            src[e[2:0]] = 1'b1;
            tick(3);
            x = e[7] ? {idl, act} : {act, idl};
            `CHK("active", x, pins)
        end
        src = '0;
        xfer(8'h80, 32'h2800);
        for (int k = 0; k < 2; k++) begin
            v = dB;
            lost = 1;
            tick(1);
            lost = 0;
            tick(3);
            `CHK("toggle", ~v, dB)
        end
        stp = 1;
        tick(2);
        stp = 0;
        `CHK("stillAfterStep", 1'b0, still)
        src[0] = 1'b1;
        tick(1);
        src = '0;
        rd(8'h01, 32'h2);
        `CHK("statusErr", 8'h02, rx[39:32])
        tally_and_finish();
    end
endmodule : tb_gcr_bank
bind gcr_bank gcr_bank_sva gcr_bank_sva_inst (.clock(clock), .rst(rst),
    .spiCsN(spiCsN), .driver_disable_n(driver_disable_n),
    .offTimeZero(offTimeZero), .dirIn(dirIn), .hotWarning(hotWarning),
    .indexPos(indexPos), .stepIn(stepIn), .standstill(standstill),
    .recalibrate(recalibrate),
    .quietChopEnable(quietChopEnable), .motorDir(motorDir),
    .diagOutA(diagOutA), .diagOutAEn(diagOutAEn), .diagOutB(diagOutB),
    .global_configuration_flags(global_configuration_flags));
`default_nettype wire
